/* logic/ldmr_pkg.sv */
// package for lane data path mode routing constants and types
`default_nettype none
package ldmr_pkg;
	// top-level operating mode
	localparam logic OP_ETHERNET = 1'b0;
	localparam logic OP_REPEATER = 1'b1;
	// rate mode codes
	typedef enum logic [2:0] {
		RATE_LAN10 = 3'h0,
		RATE_WAN10 = 3'h1,
		RATE_GBE1 = 3'h2,
		RATE_OTU2 = 3'h3,
		RATE_OTU1E = 3'h4,
		RATE_OTU2E = 3'h5
	} ldmr_rate_t;
	// serial rate codes reported per side
	typedef enum logic [2:0] {
		SR_10P3125 = 3'h0,
		SR_9P95328 = 3'h1,
		SR_1P25 = 3'h2,
		SR_10P709 = 3'h3,
		SR_11P049 = 3'h4,
		SR_11P095 = 3'h5,
		SR_NONE = 3'h7
	} ldmr_srate_t;
	// ingress line-side decoder select, one-hot, all zero when no decoder is chosen
	localparam int SEL_WIS = 0;
	localparam int SEL_PCS10 = 1;
	localparam int SEL_PCS1 = 2;
	localparam int SEL_BYPASS = 3;
	localparam int SEL_W = 4;
	// stage enable bit positions
	localparam int STG_TIMING = 0;
	localparam int STG_SECURITY = 1;
	localparam int STG_MACA = 2;
	localparam int STG_MACB = 3;
	localparam int STG_W = 4;
	// equalizer tap clock codes
	localparam logic TAPCLK_10G = 1'b0;
	localparam logic TAPCLK_1GHZ = 1'b1;
	// autoneg side codes
	localparam logic [1:0] AN_OFF = 2'h0;
	localparam logic [1:0] AN_LINE = 2'h1;
	localparam logic [1:0] AN_HOST = 2'h2;
	// timestamp step modes
	localparam logic TS_ONE_STEP = 1'b0;
	localparam logic TS_TWO_STEP = 1'b1;
	// reset values
	localparam logic [1:0] RST_AN = 2'h0;
	localparam logic [SEL_W-1:0] RST_SEL = 4'h0;
	// synchronizer filter divider default
	localparam int SYNC_FILT_SHIFT = 4;
	// cross connect channel index width
	localparam int CH_W = 2;
endpackage : ldmr_pkg
`default_nettype wire

/* logic/ldmr_dir_if.sv */
// interface carrying one direction's routing decision
`timescale 1ns/100ps
`default_nettype none
interface ldmr_dir_if;
	logic [ldmr_pkg::SEL_W-1:0] decSel;
	logic [ldmr_pkg::STG_W-1:0] stageEn;
	logic useFlowBuf;
	logic useRateFifo;
	logic elasticEn;
	logic [1:0] phaseErr;
	logic aligned;
	modport ctrl (output decSel, stageEn, useFlowBuf, useRateFifo, elasticEn, input phaseErr,
		aligned);
	modport path (input decSel, stageEn, useFlowBuf, useRateFifo, elasticEn, output phaseErr,
		aligned);
endinterface : ldmr_dir_if
`default_nettype wire

/* logic/ldmr_clock_align.sv */
// repeater clock alignment filter for one direction
`timescale 1ns/100ps
`default_nettype none
module ldmr_clock_align #(
	parameter int ACC_W = 12
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic phaseUp,
	input wire logic phaseDn,
	ldmr_dir_if.path dir
);
	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic [1:0] err;
		logic lock;
	} ldmr_ca_t;
	ldmr_ca_t st_q;
	ldmr_ca_t st_d;
	localparam logic [ACC_W-1:0] MID = {1'b1, {(ACC_W-1){1'b0}}};
	////////////////////////////////////////////////////////////////
	always_comb begin
		st_d = st_q;
		if (!dir.elasticEn) begin
			st_d.acc = MID;
			st_d.err = 2'h0;
			st_d.lock = 1'b0;
		end else begin
			// slow integrating filter tracks wander only
			if (phaseUp && !phaseDn && st_q.acc != {ACC_W{1'b1}}) st_d.acc = st_q.acc + 1'b1;
			else if (phaseDn && !phaseUp && st_q.acc != '0) st_d.acc = st_q.acc - 1'b1;
			st_d.err = {phaseUp, phaseDn};
			st_d.lock = (st_q.acc[ACC_W-1 -: ldmr_pkg::SYNC_FILT_SHIFT] ==
				MID[ACC_W-1 -: ldmr_pkg::SYNC_FILT_SHIFT]);
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) st_q <= '{acc: MID, err: 2'h0, lock: 1'b0};
		else if (clkEn) st_q <= st_d;
	end
	assign dir.phaseErr = st_q.err;
	assign dir.aligned = st_q.lock;
endmodule : ldmr_clock_align
`default_nettype wire

/* logic/ldmr_lane.sv */
// lane mode and routing control top
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - ethernet mode or repeater bypass per lane
// - ingress line to host, egress reverse
// - repeater tx clock aligned via filtered synchronizer
// - both repeater directions built identically
// - repeater host rate equals line rate
// - wan ingress routes through wis stage
// - lan to 10g pcs, 1g to 1g pcs
// - timing, security, macs each bypassable
// - host pcs chosen by rate mode
// - 10g egress host pcs to line pcs
// - wan egress frames via wis at 9.953
// - 1g egress via 1g pcs at 1.25
// - wan pairs 9.95328 line with 10.3125 host
// - macs off in ethernet mode uses rate compensating fifo
// - macs on uses flow control buffer
// - autoneg on one side only
// - tap registers clocked by serial clock
// - cross connect switches on selected events
// - one 1g pcs per side, both coded
// - timing stage supports one and two step
// - rx and tx share one rate mode
module ldmr_lane #(
	parameter int NUM_CH = 4,
	parameter int EVT_W = 4
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic cfgRepeater,
	input wire logic [2:0] cfgRate,
	input wire logic [ldmr_pkg::STG_W-1:0] cfgIngStages,
	input wire logic [ldmr_pkg::STG_W-1:0] cfgEgrStages,
	input wire logic cfgWisEn,
	input wire logic [1:0] cfgAnReq,
	input wire logic cfgTwoStep,
	input wire logic [ldmr_pkg::CH_W-1:0] cfgXcDefault,
	input wire logic [ldmr_pkg::CH_W-1:0] cfgXcAlt,
	input wire logic [EVT_W-1:0] cfgXcEvtMask,
	input wire logic [EVT_W-1:0] xcEvents,
	input wire logic ingPhaseUp,
	input wire logic ingPhaseDn,
	input wire logic egrPhaseUp,
	input wire logic egrPhaseDn,
	output logic [ldmr_pkg::SEL_W-1:0] ingDecSel,
	output logic [ldmr_pkg::SEL_W-1:0] egrEncSel,
	output logic ingHostPcs10,
	output logic ingHostPcs1,
	output logic egrHostPcs10,
	output logic egrHostPcs1,
	output logic [ldmr_pkg::STG_W-1:0] ingStageEn,
	output logic [ldmr_pkg::STG_W-1:0] egrStageEn,
	output logic useFlowBuf,
	output logic useRateFifo,
	output logic elasticEn,
	output logic [2:0] lineRate,
	output logic [2:0] hostRate,
	output logic [1:0] anSide,
	output logic tapClkSel,
	output logic tsTwoStep,
	output logic [ldmr_pkg::CH_W-1:0] xcSel,
	output logic xcSwitched,
	output logic ingAligned,
	output logic egrAligned,
	output logic [1:0] ingPhaseErr,
	output logic [1:0] egrPhaseErr,
	output logic cfgError
);
	typedef struct packed {
		logic [ldmr_pkg::SEL_W-1:0] ingSel;
		logic [ldmr_pkg::SEL_W-1:0] egrSel;
		logic [3:0] hostPcs;
		logic [ldmr_pkg::STG_W-1:0] ingStg;
		logic [ldmr_pkg::STG_W-1:0] egrStg;
		logic flowBuf;
		logic rateFifo;
		logic elastic;
		logic [2:0] lRate;
		logic [2:0] hRate;
		logic [1:0] an;
		logic tapClk;
		logic twoStep;
		logic [ldmr_pkg::CH_W-1:0] xc;
		logic xcSw;
		logic xcAlt;
		logic [1:0] ingErr;
		logic [1:0] egrErr;
		logic ingAl;
		logic egrAl;
		logic err;
	} ldmr_st_t;
	ldmr_st_t st_q;
	ldmr_st_t st_d;
	////////////////////////////////////////////////////////////////
	// direction carriers and alignment paths
	ldmr_dir_if ingDir ();
	ldmr_dir_if egrDir ();
	// same alignment module for both directions
	ldmr_clock_align #(.ACC_W(12)) u_ing_align (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.phaseUp(ingPhaseUp),
		.phaseDn(ingPhaseDn),
		.dir(ingDir.path)
	);
	ldmr_clock_align #(.ACC_W(12)) u_egr_align (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.phaseUp(egrPhaseUp),
		.phaseDn(egrPhaseDn),
		.dir(egrDir.path)
	);
	assign ingDir.decSel = st_q.ingSel;
	assign ingDir.stageEn = st_q.ingStg;
	assign ingDir.useFlowBuf = st_q.flowBuf;
	assign ingDir.useRateFifo = st_q.rateFifo;
	assign ingDir.elasticEn = st_q.elastic;
	assign egrDir.decSel = st_q.egrSel;
	assign egrDir.stageEn = st_q.egrStg;
	assign egrDir.useFlowBuf = st_q.flowBuf;
	assign egrDir.useRateFifo = st_q.rateFifo;
	assign egrDir.elasticEn = st_q.elastic;
	////////////////////////////////////////////////////////////////
	// line decoder select for a rate mode
	function automatic logic [ldmr_pkg::SEL_W-1:0] lineSel(input logic rep, input logic [2:0] r,
		input logic wis);
		logic [ldmr_pkg::SEL_W-1:0] s;
		s = '0;
		if (rep) s[ldmr_pkg::SEL_BYPASS] = 1'b1;
		else if (r == ldmr_pkg::RATE_WAN10 && wis) s[ldmr_pkg::SEL_WIS] = 1'b1;
		else if (r == ldmr_pkg::RATE_LAN10) s[ldmr_pkg::SEL_PCS10] = 1'b1;
		else if (r == ldmr_pkg::RATE_GBE1) s[ldmr_pkg::SEL_PCS1] = 1'b1;
		return s;
	endfunction : lineSel
	// serial rate for a mode code
	function automatic logic [2:0] serRate(input logic [2:0] r);
		logic [2:0] s;
		s = ldmr_pkg::SR_NONE;
		unique case (r)
			ldmr_pkg::RATE_LAN10: s = ldmr_pkg::SR_10P3125;
			ldmr_pkg::RATE_WAN10: s = ldmr_pkg::SR_9P95328;
			ldmr_pkg::RATE_GBE1: s = ldmr_pkg::SR_1P25;
			ldmr_pkg::RATE_OTU2: s = ldmr_pkg::SR_10P709;
			ldmr_pkg::RATE_OTU1E: s = ldmr_pkg::SR_11P049;
			ldmr_pkg::RATE_OTU2E: s = ldmr_pkg::SR_11P095;
			default: s = ldmr_pkg::SR_NONE;
		endcase
		return s;
	endfunction : serRate
	////////////////////////////////////////////////////////////////
	logic isOtn;
	logic isEth;
	logic isWan;
	logic is1g;
	logic illegal;
	logic anyMac;
	logic evtHit;
	assign isOtn = cfgRate == ldmr_pkg::RATE_OTU2 || cfgRate == ldmr_pkg::RATE_OTU1E ||
		cfgRate == ldmr_pkg::RATE_OTU2E;
	assign isEth = !cfgRepeater;
	assign isWan = cfgRate == ldmr_pkg::RATE_WAN10;
	assign is1g = cfgRate == ldmr_pkg::RATE_GBE1;
	// otn only in repeater, wan only in ethernet, plus unused codes
	assign illegal = cfgRate > ldmr_pkg::RATE_OTU2E || (isEth && isOtn) ||
		(cfgRepeater && isWan);
	assign anyMac = isEth && (cfgIngStages[ldmr_pkg::STG_MACA] ||
		cfgIngStages[ldmr_pkg::STG_MACB] || cfgEgrStages[ldmr_pkg::STG_MACA] ||
		cfgEgrStages[ldmr_pkg::STG_MACB]);
	assign evtHit = |(xcEvents & cfgXcEvtMask);
	always_comb begin
		st_d = st_q;
		st_d.err = illegal || cfgAnReq == 2'h3;
		if (illegal) begin
			// hold previous routing on an illegal mode
			st_d.ingSel = st_q.ingSel;
		end else begin
			// one mode code feeds both directions
			st_d.ingSel = lineSel(cfgRepeater, cfgRate, cfgWisEn);
			st_d.egrSel = lineSel(cfgRepeater, cfgRate, cfgWisEn);
			// host pcs per direction: {egr1g, egr10g, ing1g, ing10g}
			st_d.hostPcs = isEth ? {is1g, !is1g, is1g, !is1g} : 4'h0;
			// stages bypass individually, none in repeater
			st_d.ingStg = isEth ? cfgIngStages : '0;
			st_d.egrStg = isEth ? cfgEgrStages : '0;
			st_d.flowBuf = anyMac;
			st_d.rateFifo = isEth && !anyMac;
			st_d.elastic = cfgRepeater;
			// line rate and host rate
			st_d.lRate = serRate(cfgRate);
			st_d.hRate = isWan ? ldmr_pkg::SR_10P3125 : serRate(cfgRate);
			st_d.tapClk = is1g ? ldmr_pkg::TAPCLK_1GHZ : ldmr_pkg::TAPCLK_10G;
		end
		// never both sides, line wins a double request
		unique case (cfgAnReq)
			ldmr_pkg::AN_LINE: st_d.an = ldmr_pkg::AN_LINE;
			ldmr_pkg::AN_HOST: st_d.an = ldmr_pkg::AN_HOST;
			ldmr_pkg::AN_OFF: st_d.an = ldmr_pkg::AN_OFF;
			default: st_d.an = ldmr_pkg::AN_LINE;
		endcase
		st_d.twoStep = cfgTwoStep ? ldmr_pkg::TS_TWO_STEP : ldmr_pkg::TS_ONE_STEP;
		// cross connect: event moves to alternate, path stays up
		st_d.xcSw = 1'b0;
		if (evtHit && !st_q.xcAlt) begin
			st_d.xcAlt = 1'b1;
			st_d.xcSw = 1'b1;
		end else if (cfgXcEvtMask == '0) begin
			st_d.xcAlt = 1'b0;
		end
		st_d.xc = st_d.xcAlt ? cfgXcAlt : cfgXcDefault;
		if (int'(st_d.xc) >= NUM_CH) st_d.xc = st_q.xc;
		st_d.ingErr = ingDir.phaseErr;
		st_d.egrErr = egrDir.phaseErr;
		st_d.ingAl = ingDir.aligned;
		st_d.egrAl = egrDir.aligned;
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.an <= ldmr_pkg::RST_AN;
			st_q.ingSel <= ldmr_pkg::RST_SEL;
			st_q.egrSel <= ldmr_pkg::RST_SEL;
			st_q.lRate <= ldmr_pkg::SR_NONE;
			st_q.hRate <= ldmr_pkg::SR_NONE;
		end else if (clkEn) begin
			st_q <= st_d;
		end
	end
	////////////////////////////////////////////////////////////////
	// outputs straight from state
	assign ingDecSel = st_q.ingSel;
	assign egrEncSel = st_q.egrSel;
	assign ingHostPcs10 = st_q.hostPcs[0];
	assign ingHostPcs1 = st_q.hostPcs[1];
	assign egrHostPcs10 = st_q.hostPcs[2];
	assign egrHostPcs1 = st_q.hostPcs[3];
	assign ingStageEn = st_q.ingStg;
	assign egrStageEn = st_q.egrStg;
	assign useFlowBuf = st_q.flowBuf;
	assign useRateFifo = st_q.rateFifo;
	assign elasticEn = st_q.elastic;
	assign lineRate = st_q.lRate;
	assign hostRate = st_q.hRate;
	assign anSide = st_q.an;
	assign tapClkSel = st_q.tapClk;
	assign tsTwoStep = st_q.twoStep;
	assign xcSel = st_q.xc;
	assign xcSwitched = st_q.xcSw;
	assign ingAligned = st_q.ingAl;
	assign egrAligned = st_q.egrAl;
	assign ingPhaseErr = st_q.ingErr;
	assign egrPhaseErr = st_q.egrErr;
	assign cfgError = st_q.err;
endmodule : ldmr_lane
`default_nettype wire

/* test/ldmr_phase_src.sv */
// phase detector source standing for the far-side clock
`timescale 1ns/100ps
`default_nettype none
module ldmr_phase_src (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic slow,
	output logic up,
	output logic dn
);
	logic [1:0] stepCnt_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) stepCnt_q <= 2'h0;
		else stepCnt_q <= stepCnt_q + 2'h1;
	end
	// drift bounded only with slow set, early steps first
	assign up = stepCnt_q == 2'h0;
	assign dn = slow && stepCnt_q == 2'h2;
endmodule : ldmr_phase_src
`default_nettype wire

/* test/ldmr_lane_sva.sv */
// checker for lane mode routing
`timescale 1ns/100ps
`default_nettype none
module ldmr_lane_sva #(
	parameter int NUM_CH = 4
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic cfgRepeater,
	input wire logic [2:0] cfgRate,
	input wire logic [3:0] cfgIngStages,
	input wire logic [3:0] cfgEgrStages,
	input wire logic cfgWisEn,
	input wire logic [1:0] cfgAnReq,
	input wire logic [1:0] cfgXcAlt,
	input wire logic [3:0] cfgXcEvtMask,
	input wire logic [3:0] xcEvents,
	input wire logic [3:0] ingDecSel,
	input wire logic [3:0] egrEncSel,
	input wire logic [3:0] ingStageEn,
	input wire logic useFlowBuf,
	input wire logic useRateFifo,
	input wire logic [2:0] lineRate,
	input wire logic [2:0] hostRate,
	input wire logic [1:0] anSide,
	input wire logic tapClkSel,
	input wire logic [1:0] xcSel,
	input wire logic xcSwitched,
	input wire logic cfgError
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic ok;
	logic mac;
	assign ok = clkEn && cfgAnReq != 2'h3 && cfgRate <= 3'h5
		&& (cfgRepeater ? cfgRate != 3'h1 : cfgRate < 3'h3);
	assign mac = cfgIngStages[2] | cfgIngStages[3] | cfgEgrStages[2] | cfgEgrStages[3];
	a_stage_bypass: assert property (ok |=> ingStageEn == ($past(cfgRepeater) ? 4'h0 : $past(cfgIngStages))) else $error("stage enables wrong");
	a_flow_buffer: assert property (ok |=> useFlowBuf == (!$past(cfgRepeater) && $past(mac))) else $error("flow buffer select wrong");
	a_rate_fifo: assert property (ok |=> useRateFifo == (!$past(cfgRepeater) && !$past(mac))) else $error("rate fifo select wrong");
	a_wan_rates: assert property (ok && !cfgRepeater && cfgRate == 3'h1 |=> lineRate == 3'h1 && hostRate == 3'h0) else $error("wan rates wrong");
	a_repeat_rates: assert property (ok && cfgRepeater |=> lineRate == hostRate && ingDecSel == 4'h8) else $error("repeater rates differ");
	a_wis_ingress: assert property (ok && !cfgRepeater && cfgRate == 3'h1 && cfgWisEn |=> ingDecSel == 4'h1) else $error("wan not via wis");
	a_same_select: assert property ($onehot0(ingDecSel) && ingDecSel == egrEncSel) else $error("directions disagree");
	a_an_single: assert property (clkEn && cfgAnReq == 2'h3 |=> anSide == 2'h1 && cfgError) else $error("autoneg on both sides");
	a_tap_clock: assert property (ok |=> tapClkSel == ($past(cfgRate) == 3'h2)) else $error("tap clock wrong");
	a_xc_switch: assert property (clkEn && |(xcEvents & cfgXcEvtMask) && cfgXcAlt < NUM_CH |=> xcSel == $past(cfgXcAlt)) else $error("no switch on event");
	a_xc_pulse: assert property (xcSwitched && clkEn |=> !xcSwitched) else $error("switch pulse too long");
	c_repeater: cover property (ok && cfgRepeater);
	c_switch: cover property (xcSwitched);
	c_refused: cover property (cfgError);
endmodule : ldmr_lane_sva
bind ldmr_lane ldmr_lane_sva #(.NUM_CH(NUM_CH)) ldmr_lane_sva_inst (.core_clk, .rst_n, .clkEn,
	.cfgRepeater, .cfgRate, .cfgIngStages, .cfgEgrStages, .cfgWisEn, .cfgAnReq, .cfgXcAlt,
	.cfgXcEvtMask, .xcEvents, .ingDecSel, .egrEncSel, .ingStageEn, .useFlowBuf, .useRateFifo,
	.lineRate, .hostRate, .anSide, .tapClkSel, .xcSel, .xcSwitched, .cfgError);
`default_nettype wire

/* test/ldmr_lane_bench.sv */
// testbench for lane mode routing
`timescale 1ns/100ps
`default_nettype none
module ldmr_lane_bench;
	logic core_clk, rst_n, clkEn, rep, wis, two, slow, ih10, ih1, eh10, eh1, flowBuf, rateFifo;
	logic elastic, tap, tsTwo, xcSw, ingAl, egrAl, cfgErr, ingUp, ingDn, egrUp, egrDn;
	logic [2:0] rate, lineR, hostR;
	logic [3:0] ingS, egrS, mask, evt, decSel, encSel, ingSt, egrSt;
	logic [1:0] an, xcD, xcA, anSide, xcSel, ingPe, egrPe;
	int n_mismatch = 0;
	int num_checks = 0;
	ldmr_lane ldmr_lane_inst (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
		.cfgRepeater(rep), .cfgRate(rate), .cfgIngStages(ingS), .cfgEgrStages(egrS),
		.cfgWisEn(wis), .cfgAnReq(an), .cfgTwoStep(two), .cfgXcDefault(xcD), .cfgXcAlt(xcA),
		.cfgXcEvtMask(mask), .xcEvents(evt), .ingPhaseUp(ingUp), .ingPhaseDn(ingDn),
		.egrPhaseUp(egrUp), .egrPhaseDn(egrDn), .ingDecSel(decSel), .egrEncSel(encSel),
		.ingHostPcs10(ih10), .ingHostPcs1(ih1), .egrHostPcs10(eh10), .egrHostPcs1(eh1),
		.ingStageEn(ingSt), .egrStageEn(egrSt), .useFlowBuf(flowBuf), .useRateFifo(rateFifo),
		.elasticEn(elastic), .lineRate(lineR), .hostRate(hostR), .anSide(anSide),
		.tapClkSel(tap), .tsTwoStep(tsTwo), .xcSel(xcSel), .xcSwitched(xcSw),
		.ingAligned(ingAl), .egrAligned(egrAl), .ingPhaseErr(ingPe), .egrPhaseErr(egrPe),
		.cfgError(cfgErr));
	ldmr_phase_src ldmr_phase_src_inst[1:0] (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
		.up({egrUp, ingUp}), .dn({egrDn, ingDn}));
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic settle;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : settle
	// phase error bits seen over one full drift period
	task automatic chkPhase(input logic [3:0] exp);
		logic [3:0] seen;
		seen = 4'h0;
		repeat (4) begin
			@(posedge core_clk);
			#1;
			seen = seen | {ingPe, egrPe};
		end
		chk(seen, exp);
	endtask : chkPhase
	// config moves only between checks, lane idle
	task automatic setCfg(input logic r, input logic [2:0] m, input logic [3:0] e);
		@(posedge core_clk);
		rep <= r;
		rate <= m;
		egrS <= e;
		settle;
	endtask : setCfg
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		#400000;
		n_mismatch++;
		test_done;
	end
	initial begin
		logic [3:0] r, m, sel;
		{rst_n, rep, rate, wis, an, two, mask, evt, slow} = '0;
		{clkEn, ingS, egrS, xcD, xcA} = {1'b1, 4'h3, 4'h3, 2'h1, 2'h2};
		wis = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		chk({1'b0, lineR}, 4'h7);
		@(posedge core_clk);
		rst_n <= 1'b1;
		for (r = 0; r < 2; r++) for (m = 0; m < 6; m++) if (r[0] ? m != 1 : m < 3) begin
			setCfg(r[0], m[2:0], 4'h3);
			sel = r[0] ? 4'h8 : m == 1 ? 4'h1 : m == 0 ? 4'h2 : 4'h4;
			chk(decSel, sel);
			chk(encSel, sel);
			chk({1'b0, lineR}, m);
			chk({1'b0, hostR}, m == 1 ? 4'h0 : m);
			chk({ih10, ih1, eh10, eh1}, r[0] ? 4'h0 : m == 2 ? 4'h5 : 4'ha);
			chk(ingSt, r[0] ? 4'h0 : 4'h3);
			chk({elastic, tap, rateFifo, 1'b0}, {r[0], m == 2, !r[0], 1'b0});
		end
		repeat (8) @(posedge core_clk);
		#1;
		chk({2'h0, ingAl, egrAl}, 4'h3);
		chkPhase(4'ha);
		@(posedge core_clk);
		slow <= 1'b1;
		settle;
		chkPhase(4'hf);
		setCfg(1'b0, 3'h0, 4'h8);
		chk({egrSt[3], flowBuf, rateFifo, 1'b0}, 4'hc);
		chk(egrSt, 4'h8);
		setCfg(1'b0, 3'h3, 4'h8);
		chk({cfgErr, decSel[2:0]}, 4'ha);
		setCfg(1'b1, 3'h1, 4'h8);
		chk({cfgErr, elastic, decSel[1:0]}, 4'ha);
		setCfg(1'b0, 3'h6, 4'h8);
		chk({cfgErr, decSel[2:0]}, 4'ha);
		for (m = 1; m < 4; m++) begin
			@(posedge core_clk);
			an <= m[1:0];
			settle;
			chk({2'h0, anSide}, m == 3 ? 4'h1 : m);
		end
		@(posedge core_clk);
		{an, two, rate} <= {2'h0, 1'b1, 3'h0};
		settle;
		chk({tsTwo, 1'b0, xcSel}, 4'h9);
		chk({cfgErr, 1'b0, anSide}, 4'h0);
		@(posedge core_clk);
		{mask, evt} <= 8'h22;
		@(posedge core_clk);
		#1;
		chk({xcSw, 1'b0, xcSel}, 4'ha);
		@(posedge core_clk);
		#1;
		chk({3'h0, xcSw}, 4'h0);
		@(posedge core_clk);
		{wis, rate} <= {1'b0, 3'h1};
		settle;
		chk(encSel, 4'h0);
		chk({1'b0, hostR}, 4'h0);
		@(posedge core_clk);
		clkEn <= 1'b0;
		rate <= 3'h2;
		settle;
		chk(decSel, 4'h0);
		chk({1'b0, lineR}, 4'h1);
		test_done;
	end
endmodule : ldmr_lane_bench
`default_nettype wire
